// *** hw/adcc_pkg.sv ***
// Shared types and constants for the converter control block
// Assumes one clock (ref_clk, 40 MHz) and an AXI4-Lite master with 8-bit byte addresses
package adcc_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DBG = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_AVG = 8'h0c;
  localparam logic [7:0] REG_SWTRIG = 8'h10;
  localparam logic [7:0] REG_FLAGS = 8'h14;
  localparam logic [7:0] REG_INTEN = 8'h18;
  localparam logic [7:0] REG_RESULT = 8'h1c;
  localparam logic [7:0] REG_WINCTRL = 8'h20;
  localparam logic [7:0] REG_WINLO = 8'h24;
  localparam logic [7:0] REG_WINHI = 8'h28;
  localparam logic [7:0] REG_GAIN_CORRECTION_REGISTER = 8'h2c;
  localparam logic [7:0] REG_OFFCORR = 8'h30;
  localparam logic [7:0] REG_CALIBRATION_REGISTER = 8'h34;

  // Bit positions inside the small registers
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SOFTWARE_RESET_BIT_BIT = 1;
  localparam int SWTRIG_START_BIT = 0;
  localparam int FLG_RESULT_READY_FLAG = 0;
  localparam int FLG_OVR = 1;
  localparam int FLG_WIN = 2;
  localparam int FLG_SYNCBUSY = 3;

  // Resolution select codes
  localparam logic [1:0] RESSEL_12 = 2'h0;
  localparam logic [1:0] RESSEL_16 = 2'h1;
  localparam logic [1:0] RESSEL_10 = 2'h2;
  localparam logic [1:0] RESSEL_8 = 2'h3;

  // Window monitor modes
  localparam logic [1:0] WIN_OFF = 2'h0;
  localparam logic [1:0] WIN_ABOVE = 2'h1;
  localparam logic [1:0] WIN_BELOW = 2'h2;
  localparam logic [1:0] WIN_INSIDE = 2'h3;

  // Values after reset and accumulation limits
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [11:0] GAIN_RST = 12'h800;
  localparam logic [3:0] MAX_SAMPLENUM = 4'ha;
  localparam logic [3:0] AUTOSHIFT_BASE = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Configuration register layout, LSB last
  typedef struct packed {
    logic [1:0] rsvd;
    logic [3:0] scan_len;
    logic [3:0] muxneg;
    logic [4:0] muxpos;
    logic [3:0] gain;
    logic [3:0] refsel;
    logic [1:0] rsvd2;
    logic corr_en;
    logic ev_start_en;
    logic freerun;
    logic diff_signed;
    logic left_adj;
    logic [1:0] ressel;
  } adcc_cfg_t;

  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] adjres;
    logic [3:0] samplenum;
  } adcc_avg_t;

  // Request toward the analog front end
  typedef struct packed {
    logic start;
    logic [4:0] muxpos;
    logic [3:0] muxneg;
    logic [3:0] gain;
    logic [3:0] refsel;
    logic [3:0] bits;
    logic diff;
    logic [10:0] calibration_register;
  } adcc_fe_req_t;

  // Answer from the analog front end, data right-aligned at the requested width
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adcc_fe_res_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } adcc_fsm_t;

endpackage

// *** hw/adcc_sync.sv ***
// Toggle-based pulse and word crossing toward the conversion side
// Assumes src_pulse is one cycle wide and src_data is valid in that cycle
`timescale 1ns/100ps
module adcc_sync
  import adcc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic src_pulse,
  input wire logic [WIDTH-1:0] src_data,
  output logic dst_pulse,
  output logic [WIDTH-1:0] dst_data,
  output logic busy
);

  typedef struct packed {
    logic tog;
    logic s1;
    logic s2;
    logic s3;
    logic [WIDTH-1:0] hold;
    logic dst_pulse;
    logic [WIDTH-1:0] dst_data;
    logic busy;
  } adcc_sync_st_t;

  adcc_sync_st_t st_ff;
  adcc_sync_st_t nxt_st;

  // Word is held steady while the toggle travels, so it is safe to sample on arrival
  always_comb begin
    nxt_st = st_ff;
    if (src_pulse) begin
      nxt_st.tog = ~st_ff.tog;
      nxt_st.hold = src_data;
    end
    nxt_st.s1 = st_ff.tog;
    nxt_st.s2 = st_ff.s1; // First stage feeds only this flop
    nxt_st.s3 = st_ff.s2;
    nxt_st.dst_pulse = st_ff.s2 ^ st_ff.s3;
    if (st_ff.s2 ^ st_ff.s3) begin
      nxt_st.dst_data = st_ff.hold;
    end
    nxt_st.busy = nxt_st.tog ^ st_ff.s3;
    if (!rst_n) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign dst_pulse = st_ff.dst_pulse;
  assign dst_data = st_ff.dst_data;
  assign busy = st_ff.busy;

endmodule // adcc_sync

// *** hw/adcc_ctrl.sv ***
// Conversion control: AXI4-Lite registers, start sequencing, accumulation, correction, window monitor
// Assumes a front end that answers each start pulse with exactly one done pulse carrying the sample
`timescale 1ns/100ps
// How it works
// - Resolution 8, 10 or 12 bits; the requested bit count is passed to the front end
// - Result placed left- or right-aligned, signed in differential mode, else unsigned
// - Conversion starts from software trigger register or from the event input
// - Exactly one event input starts conversions
// - Single, free-running and scan over consecutive positive inputs
// - Window monitor compares a chosen channel's result against two thresholds
// - Accumulation of up to 1024 samples, shifted to fit 16 bits
// - Positive select five bits, negative select four bits
// - Internal sources are simply further codes of the positive select
// - Four-bit reference select passed to the front end
// - Four-bit gain code passed to the front end
// - Hardware gain and offset correction from the correction registers
// - Next conversion launched the same cycle the previous one completes
// - No clock gating; logic keeps running whenever its clock runs
// - Interrupt line and single-cycle event outputs for result and window
// - Configuration writes cross to the conversion side before taking effect
// - Debug halt stops new sequences unless run-in-debug is set; scan and accumulation steps already begun continue
// - Protected writes refused except to the flag register
// - Protection lifted during debug halt, extended reset or debugger access
// - Software reset restores all registers except debug control and disables
// - Each finished result overwrites the result register
// - New result while previous unread sets the overrun flag
// - Resolution selects 12 bits after reset
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int ACC_W = 23
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output adcc_fe_req_t fe_req,
  input wire adcc_fe_res_t fe_res,
  input wire logic ev_start,
  output logic ev_result_ready,
  output logic ev_window,
  output logic irq,
  input wire logic dbg_halt,
  input wire logic cpu_rst_ext,
  input wire logic dbg_access,
  input wire logic wp_en
);

  typedef struct packed {
    adcc_fsm_t fsm;
    logic en;
    logic run_dbg;
    adcc_cfg_t cfg_sh;
    adcc_cfg_t cfg;
    adcc_avg_t avg;
    logic [7:0] winctrl;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic [11:0] gain_correction_register;
    logic [11:0] offcorr;
    logic [10:0] calibration_register;
    logic [2:0] inten;
    logic [2:0] flags;
    logic [15:0] result;
    logic start_pend;
    logic [3:0] scan_idx;
    logic signed [ACC_W-1:0] acc;
    logic [10:0] acc_cnt;
    adcc_fe_req_t fe;
    logic irq;
    logic ev_result_ready_flag;
    logic ev_win;
    logic trig_pulse;
    logic cfg_pulse;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcc_st_t;

  adcc_st_t st_ff;
  adcc_st_t nxt_st;

  logic trig_go;
  logic trig_busy;
  logic cfg_go;
  logic [31:0] cfg_data;
  logic cfg_busy;

  // Software start crossing
  adcc_sync #(.WIDTH(1)) u_trig_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_pulse(st_ff.trig_pulse),
    .src_data(1'b1),
    .dst_pulse(trig_go),
    .dst_data(),
    .busy(trig_busy)
  );

  // Configuration crossing; the active copy changes only on arrival or on software reset
  adcc_sync #(.WIDTH(32)) u_cfg_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .src_pulse(st_ff.cfg_pulse),
    .src_data(st_ff.cfg_sh),
    .dst_pulse(cfg_go),
    .dst_data(cfg_data),
    .busy(cfg_busy)
  );

  // Byte-lane merge of a write into the old contents
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= REG_CALIBRATION_REGISTER);
  endfunction

  // Converted bits per resolution code; the accumulating code converts at 12
  function automatic logic [3:0] res_bits(input logic [1:0] rs);
    logic [3:0] b;
    unique case (rs)
      RESSEL_10: b = 4'ha;
      RESSEL_8: b = 4'h8;
      default: b = 4'hc;
    endcase
    return b;
  endfunction

  function automatic logic [31:0] read_reg(input adcc_st_t s, input logic [7:0] a, input logic busy);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      REG_CTRL: r[CTRL_EN_BIT] = s.en;
      REG_DBG: r[0] = s.run_dbg;
      REG_CFG: r = s.cfg_sh;
      REG_AVG: r = s.avg;
      REG_FLAGS: r = {28'h0, busy, s.flags};
      REG_INTEN: r = {29'h0, s.inten};
      REG_RESULT: r = {16'h0, s.result};
      REG_WINCTRL: r = {24'h0, s.winctrl};
      REG_WINLO: r = {16'h0, s.win_lo};
      REG_WINHI: r = {16'h0, s.win_hi};
      REG_GAIN_CORRECTION_REGISTER: r = {20'h0, s.gain_correction_register};
      REG_OFFCORR: r = {20'h0, s.offcorr};
      REG_CALIBRATION_REGISTER: r = {21'h0, s.calibration_register};
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  // Mask to width, sign-extend in differential mode, then correct and clamp to 12 bits
  function automatic logic signed [12:0] cond_sample(input logic [11:0] d, input adcc_cfg_t c,
                                                     input logic [11:0] g, input logic [11:0] o);
    logic [3:0] w;
    logic [12:0] m;
    logic signed [12:0] v;
    logic signed [25:0] p;
    w = res_bits(c.ressel);
    m = 13'((13'h1 << w) - 13'h1);
    v = signed'({1'b0, d} & m);
    if (c.diff_signed && d[w - 4'h1]) begin
      v = v | signed'(~m);
    end
    p = 26'(v);
    if (c.corr_en) begin
      p = ((26'(v) - 26'(signed'(o))) * 26'(signed'({1'b0, g}))) >>> 11;
      if (c.diff_signed) begin
        p = (p > 26'sd2047) ? 26'sd2047 : ((p < -26'sd2048) ? -26'sd2048 : p);
      end else begin
        p = (p > 26'sd4095) ? 26'sd4095 : ((p < 26'sd0) ? 26'sd0 : p);
      end
    end
    return 13'(p);
  endfunction

  // Window test on the final value, signed in differential mode
  function automatic logic win_hit(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi,
                                   input logic [1:0] mode, input logic sgn);
    logic above;
    logic below;
    above = sgn ? (signed'(v) > signed'(lo)) : (v > lo);
    below = sgn ? (signed'(v) < signed'(hi)) : (v < hi);
    unique case (mode)
      WIN_ABOVE: return above;
      WIN_BELOW: return below;
      WIN_INSIDE: return above && below;
      default: return 1'b0;
    endcase
  endfunction

  logic halted;
  logic prot;
  logic ev_go;
  logic accum;
  logic [3:0] n_log;
  logic [10:0] nsamp;
  logic [4:0] shift;
  logic [4:0] fmt_w;
  logic signed [12:0] sample;
  logic signed [ACC_W-1:0] acc_sum;
  logic [15:0] fin;
  logic [31:0] wv;
  logic [2:0] set_f;
  logic [2:0] clr_f;
  logic do_software_reset_bit;
  logic launch;

  // Whole next state: bus slave, conversion sequencing, flags, then resets
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev_result_ready_flag = 1'b0;
    nxt_st.ev_win = 1'b0;
    nxt_st.trig_pulse = 1'b0;
    nxt_st.cfg_pulse = 1'b0;
    set_f = 3'h0;
    clr_f = 3'h0;
    do_software_reset_bit = 1'b0;
    launch = 1'b0;
    fin = 16'h0;
    halted = dbg_halt && !st_ff.run_dbg;
    prot = wp_en && !(dbg_halt || cpu_rst_ext || dbg_access);
    ev_go = ev_start && st_ff.cfg.ev_start_en;
    accum = st_ff.cfg.ressel == RESSEL_16;
    n_log = (accum) ? ((st_ff.avg.samplenum > MAX_SAMPLENUM) ? MAX_SAMPLENUM : st_ff.avg.samplenum) : 4'h0;
    nsamp = 11'(11'h1 << n_log);
    shift = (n_log > AUTOSHIFT_BASE) ? 5'(n_log - AUTOSHIFT_BASE) : 5'h0;
    if (accum) begin
      shift = 5'(shift + 5'(st_ff.avg.adjres));
    end
    fmt_w = accum ? 5'd16 : 5'(res_bits(st_ff.cfg.ressel));
    sample = cond_sample(fe_res.data, st_ff.cfg, st_ff.gain_correction_register, st_ff.offcorr);
    acc_sum = ACC_W'(st_ff.acc + ACC_W'(sample));
    wv = wmerge(read_reg(st_ff, st_ff.aw_addr, 1'b0), st_ff.w_data, st_ff.w_strb);

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if (!is_mapped(st_ff.aw_addr)) begin
        nxt_st.bresp = RESP_SLVERR;
      end else if (prot && st_ff.aw_addr != REG_FLAGS) begin
        nxt_st.bresp = RESP_SLVERR;
      end else begin
        case (st_ff.aw_addr)
          REG_CTRL: begin
            nxt_st.en = wv[CTRL_EN_BIT];
            do_software_reset_bit = wv[CTRL_SOFTWARE_RESET_BIT_BIT];
          end
          REG_DBG: nxt_st.run_dbg = wv[0];
          REG_CFG: begin
            nxt_st.cfg_sh = adcc_cfg_t'(wv);
            nxt_st.cfg_pulse = 1'b1;
          end
          REG_AVG: nxt_st.avg = adcc_avg_t'({24'h0, wv[7:0]});
          REG_SWTRIG: nxt_st.trig_pulse = wv[SWTRIG_START_BIT];
          REG_FLAGS: clr_f = wv[2:0];
          REG_INTEN: nxt_st.inten = wv[2:0];
          REG_WINCTRL: nxt_st.winctrl = wv[7:0];
          REG_WINLO: nxt_st.win_lo = wv[15:0];
          REG_WINHI: nxt_st.win_hi = wv[15:0];
          REG_GAIN_CORRECTION_REGISTER: nxt_st.gain_correction_register = wv[11:0];
          REG_OFFCORR: nxt_st.offcorr = wv[11:0];
          REG_CALIBRATION_REGISTER: nxt_st.calibration_register = wv[10:0];
          default: nxt_st.bresp = RESP_OKAY;
        endcase
      end
    end

    // Read channel; reading the result consumes the ready flag
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = read_reg(st_ff, s_axi_araddr, trig_busy || cfg_busy);
      nxt_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == REG_RESULT) begin
        clr_f[FLG_RESULT_READY_FLAG] = 1'b1;
      end
    end

    // Arrivals from the crossings
    if (cfg_go) begin
      nxt_st.cfg = adcc_cfg_t'(cfg_data);
    end
    if (trig_go) begin
      nxt_st.start_pend = 1'b1;
    end

    // Conversion sequencing
    unique case (st_ff.fsm)
      ST_IDLE: begin
        if (st_ff.en && !halted && (nxt_st.start_pend || ev_go)) begin
          launch = 1'b1;
          nxt_st.acc = '0;
          nxt_st.acc_cnt = 11'h0;
          nxt_st.fsm = ST_CONV;
        end
      end
      ST_CONV: begin
        if (ev_go) begin
          nxt_st.start_pend = 1'b1;
        end
        if (fe_res.done) begin
          nxt_st.acc = acc_sum;
          nxt_st.acc_cnt = 11'(st_ff.acc_cnt + 11'h1);
          if (11'(st_ff.acc_cnt + 11'h1) < nsamp) begin
            launch = 1'b1;
          end else begin
            fin = 16'(acc_sum >>> shift);
            if (win_hit(fin, st_ff.win_lo, st_ff.win_hi, st_ff.winctrl[1:0], st_ff.cfg.diff_signed) &&
                (st_ff.winctrl[2] || st_ff.winctrl[7:3] == st_ff.fe.muxpos)) begin
              set_f[FLG_WIN] = 1'b1;
              nxt_st.ev_win = 1'b1;
            end
            nxt_st.result = st_ff.cfg.left_adj ? 16'(fin << (5'd16 - fmt_w)) : fin;
            set_f[FLG_RESULT_READY_FLAG] = 1'b1;
            set_f[FLG_OVR] = st_ff.flags[FLG_RESULT_READY_FLAG];
            nxt_st.ev_result_ready_flag = 1'b1;
            nxt_st.acc = '0;
            nxt_st.acc_cnt = 11'h0;
            if (st_ff.scan_idx < st_ff.cfg.scan_len) begin
              nxt_st.scan_idx = 4'(st_ff.scan_idx + 4'h1);
              launch = 1'b1;
            end else begin
              nxt_st.scan_idx = 4'h0;
              if ((st_ff.cfg.freerun || nxt_st.start_pend) && !halted) begin
                launch = 1'b1;
              end else begin
                nxt_st.fsm = ST_IDLE;
              end
            end
          end
        end
        if (!st_ff.en) begin
          launch = 1'b0;
          nxt_st.scan_idx = 4'h0;
          nxt_st.fsm = ST_IDLE;
        end
      end
      default: nxt_st.fsm = ST_IDLE;
    endcase
    if (launch) begin
      nxt_st.start_pend = 1'b0;
    end
    nxt_st.fe.start = launch;

    // Set wins over clear
    nxt_st.flags = (st_ff.flags & ~clr_f) | set_f;

    // Software reset keeps debug control and any bus answer in flight
    if (do_software_reset_bit) begin
      nxt_st.en = 1'b0;
      nxt_st.cfg_sh = adcc_cfg_t'(CFG_RST);
      nxt_st.cfg = adcc_cfg_t'(CFG_RST);
      nxt_st.avg = '0;
      nxt_st.winctrl = 8'h0;
      nxt_st.win_lo = 16'h0;
      nxt_st.win_hi = 16'h0;
      nxt_st.gain_correction_register = GAIN_RST;
      nxt_st.offcorr = 12'h0;
      nxt_st.calibration_register = 11'h0;
      nxt_st.inten = 3'h0;
      nxt_st.flags = 3'h0;
      nxt_st.result = 16'h0;
      nxt_st.start_pend = 1'b0;
      nxt_st.scan_idx = 4'h0;
      nxt_st.acc = '0;
      nxt_st.acc_cnt = 11'h0;
      nxt_st.fe.start = 1'b0;
      nxt_st.fsm = ST_IDLE;
    end
    if (!rst_n) begin
      nxt_st = '0;
      nxt_st.cfg = adcc_cfg_t'(CFG_RST);
      nxt_st.cfg_sh = adcc_cfg_t'(CFG_RST);
      nxt_st.gain_correction_register = GAIN_RST;
      nxt_st.fsm = ST_IDLE;
    end

    // Front-end settings follow the active configuration and the scan position
    nxt_st.fe.muxpos = 5'(nxt_st.cfg.muxpos + 5'(nxt_st.scan_idx));
    nxt_st.fe.muxneg = nxt_st.cfg.muxneg;
    nxt_st.fe.gain = nxt_st.cfg.gain;
    nxt_st.fe.refsel = nxt_st.cfg.refsel;
    nxt_st.fe.bits = res_bits(nxt_st.cfg.ressel);
    nxt_st.fe.diff = nxt_st.cfg.diff_signed;
    nxt_st.fe.calibration_register = nxt_st.calibration_register;
    nxt_st.awready = !nxt_st.aw_have;
    nxt_st.wready = !nxt_st.w_have;
    nxt_st.arready = !nxt_st.rvalid;
    nxt_st.irq = |(nxt_st.flags & nxt_st.inten);
  end

  // Free-running clock, no gating, so sleep states that keep it alive keep conversions alive
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign fe_req = st_ff.fe;
  assign ev_result_ready = st_ff.ev_result_ready_flag;
  assign ev_window = st_ff.ev_win;
  assign irq = st_ff.irq;

endmodule // adcc_ctrl

// *** sim/adcc_checker.sv ***
// Port-level properties of the converter control block
// Assumes a single clock domain and bound to adcc_ctrl
`timescale 1ns/100ps
module adcc_checker
  import adcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire adcc_fe_req_t fe_req,
  input wire adcc_fe_res_t fe_res,
  input wire logic ev_result_ready,
  input wire logic ev_window,
  input wire logic dbg_halt,
  input wire logic cpu_rst_ext,
  input wire logic dbg_access,
  input wire logic wp_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic hs;
  logic lift;
  // Both write channels taken at one edge, and any reason to lift protection
  assign hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign lift = dbg_halt || cpu_rst_ext || dbg_access;
  property p_refuse;
    hs && wp_en && !lift && s_axi_awaddr != REG_FLAGS |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected write accepted");
  property p_flags_open;
    hs && wp_en && s_axi_awaddr == REG_FLAGS |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_flags_open: assert property (p_flags_open) else $error("flag write refused");
  property p_lift;
    hs && lift && s_axi_awaddr == REG_CFG |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_lift: assert property (p_lift) else $error("lifted write refused");
  property p_res;
    ev_result_ready |-> $past(fe_res.done);
  endproperty
  a_res: assert property (p_res) else $error("result event without sample");
  property p_win;
    ev_window |-> $past(fe_res.done);
  endproperty
  a_win: assert property (p_win) else $error("window event without sample");
  property p_pulse;
    fe_req.start |=> !fe_req.start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_bits;
    fe_req.start |-> fe_req.bits inside {4'hc, 4'ha, 4'h8};
  endproperty
  a_bits: assert property (p_bits) else $error("bad resolution request");
  // A start may not bypass the crossing
  property p_sync;
    hs && s_axi_awaddr == REG_SWTRIG |=> !fe_req.start [*3];
  endproperty
  a_sync: assert property (p_sync) else $error("start too early");
endmodule // adcc_checker
bind adcc_ctrl adcc_checker i_chk (.*);

// *** sim/adcc_fe_model.sv ***
// Behavioural analog front end: one done pulse per start
// Assumes start is a one-cycle pulse; dly adds conversion cycles
`timescale 1ns/100ps
module adcc_fe_model
  import adcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [3:0] dly,
  input wire logic [11:0] val,
  input wire adcc_fe_req_t req,
  output adcc_fe_res_t res
);
  int cnt = 0;
  logic fire;
  logic [11:0] noise = 12'h5a5;
  // Data wanders outside done so a stale sample is never read as fresh; each output written once per edge
  always @(posedge ref_clk) begin
    fire = !req.start && cnt == 1;
    if (req.start) cnt = dly + 1;
    else if (cnt > 0) cnt = cnt - 1;
    noise <= ~noise;
    res.done <= fire;
    res.data <= fire ? 12'(val >> (12 - req.bits)) : noise;
  end
endmodule // adcc_fe_model

// *** sim/testbench.sv ***
// Self-checking bench for adcc_ctrl over AXI4-Lite
// Assumes adcc_fe_model as the front end and the bound checker
`timescale 1ns/100ps
module testbench
  import adcc_pkg::*;
;
  logic ref_clk = '0;
  logic rst_n = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, dly = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ev_result_ready, ev_window, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  adcc_fe_req_t fe_req;
  adcc_fe_res_t fe_res;
  logic ev_start = '0, dbg_halt = '0, cpu_rst_ext = '0, dbg_access = '0, wp_en = '0;
  logic [11:0] val = 12'habc;
  int n_fail = 0, tests_run = 0;
  adcc_ctrl i_dut (.*);
  adcc_fe_model i_fe (.ref_clk, .dly, .val, .req(fe_req), .res(fe_res));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic conv(input logic ev);
    if (ev) begin
      ev_start <= 1'h1;
      @(posedge ref_clk);
      ev_start <= 1'h0;
    end else wr(REG_SWTRIG, 32'h1);
    do @(posedge ref_clk); while (!ev_result_ready);
  endtask
  task automatic t_defaults(input logic [31:0] dbgv);
    rd(REG_CFG);
    chk(d, 32'h0);
    rd(REG_GAIN_CORRECTION_REGISTER);
    chk(d, 32'h800);
    rd(REG_DBG);
    chk(d, dbgv);
  endtask
  task automatic t_formats;
    logic [1:0] code [3] = '{RESSEL_12, RESSEL_10, RESSEL_8};
    int j;
    wr(REG_CALIBRATION_REGISTER, 32'h2a5);
    wr(REG_WINCTRL, 32'h5);
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      j = i % 3;
      dly <= 4'(i);
      wr(REG_CFG, {26'h0, 3'h4, i >= 3, code[j]});
      repeat (6) @(posedge ref_clk);
      conv(i[0]);
      chk(ev_window, 1'h1);
      chk(fe_req.bits, 32'(12 - 2 * j));
      rd(REG_RESULT);
      chk(d, i < 3 ? 32'(val) >> 2 * j : 32'(val) >> 2 * j << 4 + 2 * j);
    end
    chk(fe_req.calibration_register, 32'h2a5);
    wr(REG_GAIN_CORRECTION_REGISTER, 32'h400);
    wr(REG_CFG, 32'h40);
    repeat (6) @(posedge ref_clk);
    conv(1'h0);
    rd(REG_RESULT);
    chk(d, 32'h55e);
    wr(REG_AVG, 32'h2);
    wr(REG_CFG, 32'h41);
    repeat (6) @(posedge ref_clk);
    conv(1'h0);
    rd(REG_RESULT);
    chk(d, 32'h1578);
  endtask
  task automatic t_overrun;
    wr(REG_INTEN, 32'h3);
    conv(1'h0);
    conv(1'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'h1);
    rd(REG_FLAGS);
    chk(d[2:0], 3'h7);
    wr(REG_FLAGS, 32'h7);
    @(posedge ref_clk);
    chk(irq, 1'h0);
  endtask
  task automatic t_protect;
    logic [31:0] seen = '0;
    wp_en <= 1'h1;
    wr(REG_CFG, 32'h20);
    chk(r, RESP_SLVERR);
    rd(REG_CFG);
    chk(d, 32'h41);
    wr(REG_FLAGS, 32'h7);
    chk(r, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      {dbg_halt, cpu_rst_ext, dbg_access} <= 3'h1 << k;
      wr(REG_CFG, 32'h20 + k);
      chk(r, RESP_OKAY);
    end
    {dbg_halt, cpu_rst_ext, dbg_access} <= 3'h4;
    wp_en <= 1'h0;
    wr(REG_SWTRIG, 32'h1);
    repeat (30) begin
      @(posedge ref_clk);
      chk(ev_result_ready, 1'h0);
    end
    dbg_halt <= 1'h0;
    repeat (30) begin
      @(posedge ref_clk);
      seen += 32'(ev_result_ready);
    end
    chk(seen, 32'h1);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    t_defaults(32'h0);
    t_formats;
    t_overrun;
    t_protect;
    wr(REG_DBG, 32'h1);
    dbg_halt <= 1'h1;
    conv(1'h0);
    dbg_halt <= 1'h0;
    wr(REG_CTRL, 32'h0);
    wr(REG_CTRL, 32'h2);
    t_defaults(32'h1);
    give_verdict;
  end
  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict;
  end
endmodule // testbench
